// ---- rtl/fasc_map.svh ----
// fasc_map.svh: offsets, field positions, reset values and timing counts
// of the fire alarm state controller. Definitions only.
// Assumes a 10 MHz system clock and a 32-bit classic Wishbone register bus.
`ifndef FASC_MAP_SVH
`define FASC_MAP_SVH

// clock and timebase
`define FASC_CLK_HZ        10000000
`define FASC_TICK_MS       100
`define FASC_TICK_CYC      ((`FASC_TICK_MS * `FASC_CLK_HZ) / 1000)
// least times round up to whole ticks
`define FASC_TICKS(ms)     (((ms) + `FASC_TICK_MS - 1) / `FASC_TICK_MS)

// documented delays, in milliseconds
`define FASC_GATE_MS       8000
`define FASC_WIN_MS        45000
`define FASC_SUP_MS        3000
`define FASC_OPEN_ACT_MS   3500
`define FASC_OPEN_RES_MS   600
`define FASC_INHIB_MS      3600000

// same delays in ticks
`define FASC_GATE_T        `FASC_TICKS(`FASC_GATE_MS)
`define FASC_WIN_T         `FASC_TICKS(`FASC_WIN_MS)
`define FASC_SUP_T         `FASC_TICKS(`FASC_SUP_MS)
`define FASC_OPEN_ACT_T    `FASC_TICKS(`FASC_OPEN_ACT_MS)
`define FASC_OPEN_RES_T    `FASC_TICKS(`FASC_OPEN_RES_MS)
`define FASC_INHIB_T       `FASC_TICKS(`FASC_INHIB_MS)

// dual-hit threshold and circuit count
`define FASC_DUAL_MIN      2
`define FASC_NCIRC         4

// register byte offsets
`define FASC_CTRL_OFF      8'h00
`define FASC_CTYPE_OFF     8'h04
`define FASC_COPT_OFF      8'h08
`define FASC_DUAL_OFF      8'h0c
`define FASC_STAT_OFF      8'h10
`define FASC_DLAT_OFF      8'h14

// field positions
`define FASC_CTRL_BRIG     0
`define FASC_COPT_GATED    0
`define FASC_COPT_CALLPT   4
`define FASC_COPT_ACTEOL   8
`define FASC_COPT_SUPV     12

// reset values
`define FASC_CTRL_RST      1'b1
`define FASC_CTYPE_RST     8'h00
`define FASC_COPT_RST      16'h0000
`define FASC_DUAL_RST      4'h0

`endif

// ---- rtl/fasc_pkg.sv ----
// fasc_pkg: types of the fire alarm state controller.
// Assumes fasc_map.svh supplies the numeric constants.
`include "fasc_map.svh"

package fasc_pkg;

	// circuit types held two bits per circuit
	typedef enum logic [1:0] {
		FASC_THERMAL  = 2'b00,
		FASC_SMOKE    = 2'b01,
		FASC_COMBINED = 2'b10,
		FASC_SPARE    = 2'b11
	} fasc_ctype_type;

	// per-circuit detection states
	typedef enum logic [1:0] {
		FASC_IDLE  = 2'b00,
		FASC_GATE  = 2'b01,
		FASC_WIN   = 2'b10,
		FASC_ALARM = 2'b11
	} fasc_cst_type;

	// one detector circuit as sensed by its responder
	typedef struct packed {
		logic pulse;    // end-of-line current pulse
		logic closure;  // smoke detector closed
		logic short_c;  // low resistance / short
		logic open_c;   // open circuit
	} fasc_circ_type;

	// panel switches, straps and system sources
	typedef struct packed {
		logic charger_inhibit;
		logic panel_reset;
		logic local_link;
		logic brigade_test;
		logic selftest_sw;
		logic silence;
		logic brigade_isolate;
		logic door_closed;
		logic testfire_active;
		logic remote_defect;
		logic testfire_fail;
		logic selftest_fail;
		logic watchdog_fail;
		logic batt_low;
		logic ext_defect;
		logic supply_low;
	} fasc_misc_type;

	// relay, lamp and indication outputs
	typedef struct packed {
		logic       evac_relay;
		logic       fire_relay;
		logic       defect_relay;
		logic       buzzer;
		logic       index_lamp;
		logic       self_test;
		logic       fire;
		logic       defect;
		logic [3:0] zone_alarm;
		logic [3:0] det_reset;
	} fasc_out_type;

	// whole state of the controller
	typedef struct packed {
		logic [31:0]          s1;
		logic [31:0]          s2;
		logic [31:0]          s3;
		logic [31:0]          f;
		logic [3:0]           pulse_d;
		logic [19:0]          tick_cnt;
		logic                 tick;
		logic                 blink;
		fasc_cst_type [3:0]   st;
		logic [3:0][8:0]      tmr;
		logic [3:0][5:0]      open_cnt;
		logic [3:0][4:0]      sup_cnt;
		logic [3:0]           alarm;
		logic [3:0]           cdef;
		logic                 fire;
		logic                 defect;
		logic                 self_test;
		logic                 inhib_run;
		logic [15:0]          inhib;
		logic [9:0]           dlat;
		logic                 brig;
		logic [7:0]           ctype;
		logic [15:0]          copt;
		logic [3:0]           dual;
		logic                 ack;
		logic [31:0]          dat;
		fasc_out_type         out;
	} fasc_state_type;

endpackage : fasc_pkg

// ---- rtl/fasc_top.sv ----
// fasc_top: alarm and defect state logic of a fire alarm control panel.
// Assumes one 10 MHz clock, a synchronous active-high reset, responder
// circuit states and panel switches arriving as asynchronous pins, and a
// classic Wishbone master for configuration and status.
//
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`include "fasc_map.svh"
`timescale 1ns/10ps
`default_nettype none

// timing notes for users of this block:
// every pin level is seen three to four clocks late, after the synchroniser,
// and every delay is counted in whole ticks, so a timed window may end up
// to one tick early; the tick period is the only timing parameter, and all
// delays scale with it, which keeps short ticks usable in simulation.
// the alarm, fire and defect latches favour the cause over the clear: a panel reset that meets a
// cause still present leaves the latch set, so a press never hides a fire.

module fasc_top #(
	parameter int TICK_CYCLES = `FASC_TICK_CYC
) (
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	input  wire fasc_pkg::fasc_circ_type [3:0] circ_i,
	input  wire fasc_pkg::fasc_misc_type      misc_i,
	input  wire logic                         wb_cyc_i,
	input  wire logic                         wb_stb_i,
	input  wire logic                         wb_we_i,
	input  wire logic [7:0]                   wb_adr_i,
	input  wire logic [3:0]                   wb_sel_i,
	input  wire logic [31:0]                  wb_dat_i,
	output logic [31:0]                       wb_dat_o,
	output logic                              wb_ack_o,
	output fasc_pkg::fasc_out_type            out_o
);
	import fasc_pkg::*;

	// registered state and its next value
	fasc_state_type          r;
	fasc_state_type          n;

	// filtered pin levels, split back into circuits and panel sources
	fasc_circ_type [3:0]     c;
	fasc_misc_type           m;

	// per-circuit decode, reused by every pass of the circuit loop
	fasc_ctype_type          typ;
	logic                    pr;
	logic                    brig;
	logic                    gated;
	logic                    act_eol;
	logic                    supv;
	logic                    callpt;
	logic                    open_al;
	logic                    sup_def;
	logic                    a_now;
	logic                    d_now;
	logic [5:0]              open_lim;

	// panel-wide results
	logic [3:0]              zone;
	logic [9:0]              present;
	logic                    dual_hit;
	logic                    qual;
	logic                    block;
	logic                    req;

	// next-state logic of the whole controller
	// everything starts from the held state, so a field that no branch
	// touches simply keeps its value; helpers get a value first of all
	always_comb begin
		n        = r;
		zone     = 4'h0;
		c        = r.f[15:0];
		m        = r.f[31:16];
		typ      = FASC_THERMAL;
		gated    = 1'b0;
		act_eol  = 1'b0;
		supv     = 1'b0;
		callpt   = 1'b0;
		open_al  = 1'b0;
		sup_def  = 1'b0;
		a_now    = 1'b0;
		d_now    = 1'b0;
		open_lim = 6'h00;
		pr       = m.panel_reset;
		brig     = r.brig & ~m.local_link;

		// three-stage synchroniser, a level counts once stages two and three agree
		n.s1 = {misc_i, circ_i};
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.f  = ((r.s2 ~^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.f);
		n.pulse_d = {c[3].pulse, c[2].pulse, c[1].pulse, c[0].pulse};

		// common timebase tick and slow blink for the pulsed defect relay
		if (r.tick_cnt == 20'(TICK_CYCLES - 1)) begin
			n.tick_cnt = 20'h00000;
			n.tick     = 1'b1;
		end else begin
			n.tick_cnt = r.tick_cnt + 20'h00001;
			n.tick     = 1'b0;
		end
		if (r.tick)
			n.blink = ~r.blink;

		// per-circuit evaluation
		// each pass decodes the circuit type and options first, then runs the
		// open and pulse counters, then the cause decode and the smoke sequence;
		// thermal circuits bypass the sequence so gating can never reach them
		for (int i = 0; i < `FASC_NCIRC; i++) begin
			typ     = fasc_ctype_type'(r.ctype[2*i +: 2]);
			gated   = r.copt[`FASC_COPT_GATED + i] & (typ != FASC_THERMAL);
			callpt  = r.copt[`FASC_COPT_CALLPT + i];
			act_eol = r.copt[`FASC_COPT_ACTEOL + i];
			supv    = r.copt[`FASC_COPT_SUPV + i];
			n.out.det_reset[i] = 1'b0;

			// open-circuit persistence counter
			open_lim = act_eol ? 6'(`FASC_OPEN_ACT_T) : 6'(`FASC_OPEN_RES_T);
			if (!c[i].open_c)
				n.open_cnt[i] = 6'h00;
			else if (r.tick && r.open_cnt[i] < open_lim)
				n.open_cnt[i] = r.open_cnt[i] + 6'h01;
			open_al = c[i].open_c && r.open_cnt[i] >= open_lim;

			// end-of-line pulse supervision, any edge restarts the count
			if (c[i].pulse != r.pulse_d[i])
				n.sup_cnt[i] = 5'h00;
			else if (r.tick && r.sup_cnt[i] < 5'(`FASC_SUP_T))
				n.sup_cnt[i] = r.sup_cnt[i] + 5'h01;
			sup_def = supv && (typ != FASC_THERMAL) &&
				r.sup_cnt[i] >= 5'(`FASC_SUP_T);

			case (typ)
				FASC_THERMAL: begin
					a_now = c[i].open_c;
					d_now = c[i].short_c & ~c[i].open_c;
				end
				FASC_SMOKE: begin
					a_now = 1'b0;
					d_now = c[i].short_c | sup_def;
				end
				FASC_COMBINED: begin
					a_now = open_al | (c[i].short_c & callpt);
					d_now = ~a_now & ((c[i].short_c & ~callpt) | sup_def);
				end
				default: begin
					a_now = 1'b0;
					d_now = 1'b0;
				end
			endcase

			// smoke detection sequence, not used by thermal circuits
			case (r.st[i])
				FASC_IDLE: begin
					if (typ != FASC_THERMAL && typ != FASC_SPARE && c[i].closure) begin
						if (gated) begin
							n.st[i]  = FASC_GATE;
							n.tmr[i] = 9'(`FASC_GATE_T);
						end else begin
							n.st[i]  = FASC_ALARM;
						end
					end
				end
				FASC_GATE: begin
					n.out.det_reset[i] = 1'b1;
					if (r.tick) begin
						if (r.tmr[i] <= 9'h001) begin
							n.st[i]  = FASC_WIN;
							n.tmr[i] = 9'(`FASC_WIN_T);
						end else begin
							n.tmr[i] = r.tmr[i] - 9'h001;
						end
					end
				end
				FASC_WIN: begin
					if (c[i].closure)
						n.st[i] = FASC_ALARM;
					else if (r.tick) begin
						if (r.tmr[i] <= 9'h001)
							n.st[i] = FASC_IDLE;
						else
							n.tmr[i] = r.tmr[i] - 9'h001;
					end
				end
				FASC_ALARM: begin
					if (pr && !c[i].closure)
						n.st[i] = FASC_IDLE;
				end
				default: n.st[i] = FASC_IDLE;
			endcase
			if (typ == FASC_THERMAL)
				n.st[i] = FASC_IDLE;

			// circuit alarm latch, a present cause wins over panel reset
			n.alarm[i] = a_now | (r.st[i] == FASC_ALARM) | (r.alarm[i] & ~pr);
			n.cdef[i]  = d_now;
		end


		// zone combination with one dual-hit group
		// a member alone never alarms its zone; once two members alarm, every
		// member zone in alarm reports together
		dual_hit = $countones(r.alarm & r.dual) >= `FASC_DUAL_MIN;
		for (int i = 0; i < `FASC_NCIRC; i++)
			zone[i] = r.alarm[i] & (~r.dual[i] | dual_hit);
		n.out.zone_alarm = zone;


		// fire state latch, panel reset clears it only when zones restored
		// the fire relay is normally energised and drops on fire while the brigade is connected, so a dead
		// panel also signals the brigade
		n.fire = (|zone) | (r.fire & ~pr);
		n.out.fire       = r.fire;
		n.out.evac_relay = r.fire;
		n.out.fire_relay = ~(r.fire & brig);
		n.out.index_lamp = r.fire;


		// defect sources: non-latching state, latched per-source indicators
		// the live state follows the sources, the indicators keep a history
		// until a panel reset, and a source still present sets them again
		present = {m.remote_defect, m.testfire_fail, m.watchdog_fail | m.selftest_fail,
			m.batt_low, m.ext_defect, m.supply_low, r.cdef};
		n.defect = |present;
		n.dlat   = present | (r.dlat & ~{10{pr}});
		n.out.defect       = r.defect;
		n.out.defect_relay = brig ? r.defect : (r.defect & r.blink);
		n.out.buzzer       = (~brig & r.defect) |
			(m.door_closed & (m.silence | (m.brigade_isolate & ~m.local_link)));


		// one-hour charger-inhibit low-battery period
		// started by low battery while the charger is held off, cut by reset
		if (pr)
			n.inhib_run = 1'b0;
		else if (r.inhib_run) begin
			if (r.tick) begin
				if (r.inhib <= 16'h0001)
					n.inhib_run = 1'b0;
				else
					n.inhib = r.inhib - 16'h0001;
			end
		end else if (m.charger_inhibit && m.batt_low) begin
			n.inhib_run = 1'b1;
			n.inhib     = 16'(`FASC_INHIB_T);
		end


		// self-test qualification and blocking
		// with the local link fitted the isolate switch is dead, so only the
		// link or brigade test can qualify; entry follows as blocks clear
		qual  = m.selftest_sw &
			((m.brigade_isolate & ~m.local_link) | m.brigade_test | m.local_link);
		block = pr | r.fire | (|r.alarm) | (|r.cdef) | (|r.dlat[3:0]) |
			m.testfire_active | r.inhib_run;
		n.self_test     = (qual & ~block) | (r.self_test & ~pr);
		n.out.self_test = r.self_test;


		// classic Wishbone slave, one wait state then a one-cycle ack
		// the held ack masks the request, so a master that keeps stb high
		// through the ack cycle is not taken twice; unmapped offsets ack
		// with zero data and ignore writes
		req   = wb_cyc_i & wb_stb_i & ~r.ack;
		n.ack = req;
		if (req && wb_we_i) begin
			case (wb_adr_i)
				`FASC_CTRL_OFF:
					if (wb_sel_i[0])
						n.brig = wb_dat_i[`FASC_CTRL_BRIG];
				`FASC_CTYPE_OFF:
					if (wb_sel_i[0])
						n.ctype = wb_dat_i[7:0];
				`FASC_COPT_OFF: begin
					if (wb_sel_i[0])
						n.copt[7:0] = wb_dat_i[7:0];
					if (wb_sel_i[1])
						n.copt[15:8] = wb_dat_i[15:8];
				end
				`FASC_DUAL_OFF:
					if (wb_sel_i[0])
						n.dual = wb_dat_i[3:0];
				default: ;
			endcase
		end
		if (req && !wb_we_i) begin
			case (wb_adr_i)
				`FASC_CTRL_OFF:  n.dat = {31'h00000000, r.brig};
				`FASC_CTYPE_OFF: n.dat = {24'h000000, r.ctype};
				`FASC_COPT_OFF:  n.dat = {16'h0000, r.copt};
				`FASC_DUAL_OFF:  n.dat = {28'h0000000, r.dual};
				`FASC_STAT_OFF:  n.dat = {16'h0000, r.out.zone_alarm, r.inhib_run,
					r.self_test, r.defect, r.fire, r.cdef, r.alarm};
				`FASC_DLAT_OFF:  n.dat = {22'h000000, r.dlat};
				default:         n.dat = 32'h00000000;
			endcase
		end
	end


	// state register, reset clears every latch
	// configuration returns to brigade connected, all thermal, no options
	// and no dual-hit members; the fire relay comes up energised
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r                <= '0;
			r.brig           <= `FASC_CTRL_RST;
			r.ctype          <= `FASC_CTYPE_RST;
			r.copt           <= `FASC_COPT_RST;
			r.dual           <= `FASC_DUAL_RST;
			r.out.fire_relay <= 1'b1;  // normally energised
		end else begin
			r <= n;
		end
	end


	// outputs straight from the state register
	// no output is decoded from inputs, so none can glitch between clocks
	assign wb_dat_o = r.dat;
	assign wb_ack_o = r.ack;
	assign out_o    = r.out;

endmodule : fasc_top

`default_nettype wire

// ---- tb/fasc_checker.sv ----
// fasc_checker: port-level checks of the alarm state controller.
// Assumes binding into fasc_top, one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module fasc_checker #(
	parameter int TICK_CYCLES = 4
) (
	input wire logic                          clk_i,
	input wire logic                          rst_i,
	input wire fasc_pkg::fasc_circ_type [3:0] circ_i,
	input wire fasc_pkg::fasc_misc_type       misc_i,
	input wire logic                          wb_cyc_i,
	input wire logic                          wb_stb_i,
	input wire logic                          wb_we_i,
	input wire logic [7:0]                    wb_adr_i,
	input wire logic [3:0]                    wb_sel_i,
	input wire logic [31:0]                   wb_dat_i,
	input wire logic [31:0]                   wb_dat_o,
	input wire logic                          wb_ack_o,
	input wire fasc_pkg::fasc_out_type        out_o
);
	import fasc_pkg::*;
	localparam int GC = 80 * TICK_CYCLES;
	logic [11:0] gate_cnt_r;
	logic [7:0]  pr_hist_r;
	// length of the detector hold, recent panel reset presses
	always_ff @(posedge clk_i) begin
		gate_cnt_r <= (rst_i || !out_o.det_reset[0]) ? 12'h000 : gate_cnt_r + 12'h001;
		pr_hist_r  <= rst_i ? 8'h00 : {pr_hist_r[6:0], misc_i.panel_reset};
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_fire2; out_o.fire ##1 out_o.fire; endsequence
	property p_ack; s_req |=> wb_ack_o; endproperty
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	property p_fire_out; s_fire2 |-> out_o.evac_relay && out_o.index_lamp; endproperty
	property p_relay_drop; $fell(out_o.fire_relay) |-> out_o.fire; endproperty
	property p_defect_relay; out_o.defect_relay |-> out_o.defect || $past(out_o.defect); endproperty
	property p_gate_hold; $rose(out_o.det_reset[0]) |-> out_o.det_reset[0] [*8]; endproperty
	property p_gate_len;
		$fell(out_o.det_reset[0]) |-> gate_cnt_r >= GC - TICK_CYCLES - 2 && gate_cnt_r <= GC + 2;
	endproperty
	property p_zone_fire; $rose(|out_o.zone_alarm) |-> ##[0:2] out_o.fire; endproperty
	property p_st_block; $rose(out_o.self_test) |-> !out_o.fire && !$past(out_o.fire); endproperty
	property p_fire_clear; $fell(out_o.fire) |-> |pr_hist_r; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	a_fire_out: assert property (p_fire_out) else $error("fire outputs off");
	a_relay_drop: assert property (p_relay_drop) else $error("fire relay dropped");
	a_defect_relay: assert property (p_defect_relay) else $error("defect relay");
	a_gate_hold: assert property (p_gate_hold) else $error("hold too short");
	a_gate_len: assert property (p_gate_len) else $error("gating length");
	a_zone_fire: assert property (p_zone_fire) else $error("zone without fire");
	a_st_block: assert property (p_st_block) else $error("self-test in fire");
	a_fire_clear: assert property (p_fire_clear) else $error("fire cleared");
endmodule : fasc_checker
bind fasc_top fasc_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.circ_i(circ_i), .misc_i(misc_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .out_o(out_o));
`default_nettype wire

// ---- tb/fasc_resp_model.sv ----
// fasc_resp_model: detector circuits as their responders sense them.
// Assumes the bench sets each line's condition and feeds back detector reset.
`timescale 1ns/10ps
`default_nettype none
module fasc_resp_model (
	input  wire logic                          clk_i,
	input  wire fasc_pkg::fasc_circ_type [3:0] cmd_i,
	input  wire logic [3:0]                    hold_i,
	output var fasc_pkg::fasc_circ_type [3:0]  circ_o
);
	import fasc_pkg::*;
	logic [3:0] ph_r = 4'h0;
	// free phase of the end-of-line pulse train
	always_ff @(posedge clk_i) ph_r <= ph_r + 4'h1;
	// held detectors stay open, pulses vanish on an open line
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			circ_o[i].open_c  = cmd_i[i].open_c;
			circ_o[i].short_c = cmd_i[i].short_c;
			circ_o[i].closure = cmd_i[i].closure & !hold_i[i];
			circ_o[i].pulse   = cmd_i[i].pulse & !cmd_i[i].open_c & ph_r[2];
		end
	end
endmodule : fasc_resp_model
`default_nettype wire

// ---- tb/tb_fasc_top.sv ----
// tb_fasc_top: self-checking bench of the alarm state controller.
// Assumes a 4-cycle tick and the responder model on the circuit pins.
`timescale 1ns/10ps
`default_nettype none
module tb_fasc_top;
	import fasc_pkg::*;
	typedef struct packed {
		logic [1:0] t;
		logic [15:0] o;
		logic [3:0] c;
		logic [7:0] w;
		logic [1:0] e;
		logic [1:0] k;
	} fasc_row_type;
	logic                clk_i = 1'b0;
	logic                rst_i = 1'b1;
	fasc_circ_type [3:0] st = '0;
	fasc_circ_type [3:0] circ;
	fasc_misc_type       m = '0;
	logic                cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, hi, lo;
	logic [7:0]          adr = 8'h00;
	logic [3:0]          sel = 4'h0;
	logic [31:0]         wdat = 32'h0, rdat, q;
	fasc_out_type        o;
	int                  bad_count = 0, samples_checked = 0;
	// circuit 0 type, options, line, wait, expected and mask of {fire, defect}
	fasc_row_type rows [13] = '{
		'{2'd0, 16'h0000, 4'h1, 8'd20, 2'b10, 2'b11}, '{2'd0, 16'h0000, 4'h2, 8'd20, 2'b01, 2'b11},
		'{2'd1, 16'h0000, 4'h4, 8'd20, 2'b10, 2'b10}, '{2'd0, 16'h0001, 4'h1, 8'd20, 2'b10, 2'b10},
		'{2'd2, 16'h0000, 4'h2, 8'd20, 2'b01, 2'b11}, '{2'd2, 16'h0010, 4'h2, 8'd20, 2'b10, 2'b10},
		'{2'd2, 16'h0001, 4'h1, 8'd15, 2'b00, 2'b10}, '{2'd2, 16'h0001, 4'h1, 8'd40, 2'b10, 2'b10},
		'{2'd2, 16'h0101, 4'h1, 8'd120, 2'b00, 2'b10}, '{2'd2, 16'h0101, 4'h1, 8'd170, 2'b10, 2'b10},
		'{2'd1, 16'h1000, 4'h0, 8'd100, 2'b00, 2'b01}, '{2'd1, 16'h1000, 4'h0, 8'd150, 2'b01, 2'b01},
		'{2'd1, 16'h1000, 4'h8, 8'd150, 2'b00, 2'b01}};
	// 10 MHz clock
	always #50 clk_i = ~clk_i;
	fasc_top #(.TICK_CYCLES(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .circ_i(circ), .misc_i(m),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .out_o(o));
	fasc_resp_model u_resp (.clk_i(clk_i), .cmd_i(st), .hold_i(o.det_reset), .circ_o(circ));
	// verdict and end of run
	task stop_test;
		if (bad_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test
	task hang;
		bad_count++;
		stop_test();
	endtask : hang
	task chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wt
	task rst;
		st <= '0;
		m <= '0;
		rst_i <= 1'b1;
		wt(5);
		rst_i <= 1'b0;
		wt(1);
	endtask : rst
	task pr;
		m.panel_reset <= 1'b1;
		wt(8);
		m.panel_reset <= 1'b0;
		wt(8);
	endtask : pr
	// one classic bus cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		{cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) hang();
		q = rdat;
		{cyc, stb} <= 2'b00;
		@(posedge clk_i);
	endtask : wb
	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rd
	task automatic wdr;
		int n;
		n = 0;
		while (o.det_reset[0] !== 1'b0 && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 400) hang();
	endtask : wdr
	// table cases, then reset, gating, dual-hit, defect, door and self-test cases
	initial begin
		foreach (rows[i]) begin
			rst();
			wr(8'h04, {30'h0, rows[i].t});
			wr(8'h08, {16'h0, rows[i].o});
			st[0] <= rows[i].c;
			wt(32'(rows[i].w));
			chk({o.fire, o.defect} & rows[i].k, rows[i].e);
		end
		rst();
		chk(o, 16'h4000);
		wr(8'h18, 32'hffffffff);
		wr(8'h10, 32'hffffffff);
		for (int a = 0; a < 7; a++) rd(8'(a * 4), 32'(a == 0));
		wr(8'h04, 32'h1);
		wr(8'h08, 32'h1);
		st[0] <= 4'h4;
		wt(12);
		chk(o.det_reset[0], 1'b1);
		st[0] <= 4'h0;
		wdr();
		wt(1850);
		chk(o.fire, 1'b0);
		st[0] <= 4'h4;
		wt(12);
		chk(o.det_reset[0], 1'b1);
		wdr();
		wt(12);
		chk({o.fire, o.evac_relay, o.fire_relay, o.index_lamp}, 4'hd);
		pr();
		chk(o.fire, 1'b1);
		st[0] <= 4'h0;
		pr();
		chk(o.fire, 1'b0);
		wr(8'h08, 32'h0);
		m.local_link <= 1'b1;
		st[0] <= 4'h4;
		wt(20);
		chk({o.fire, o.fire_relay}, 2'b11);
		rst();
		wr(8'h0c, 32'h3);
		st[0] <= 4'h1;
		wt(20);
		chk(|o.zone_alarm, 1'b0);
		st[1] <= 4'h1;
		wt(20);
		chk(|o.zone_alarm, 1'b1);
		rst();
		for (int i = 0; i < 7; i++) begin
			m <= fasc_misc_type'(16'h1 << i);
			wt(10);
			chk({o.defect, o.defect_relay}, 2'b11);
			m <= '0;
			wt(10);
			chk(o.defect, 1'b0);
		end
		rd(8'h14, 32'h3f0);
		m.ext_defect <= 1'b1;
		wt(10);
		pr();
		rd(8'h14, 32'h20);
		wr(8'h00, 32'h0);
		wt(10);
		chk(o.buzzer, 1'b1);
		hi = 1'b0;
		lo = 1'b0;
		repeat (12) begin
			@(posedge clk_i);
			hi |= o.defect_relay;
			lo |= !o.defect_relay;
		end
		chk({hi, lo}, 2'b11);
		rst();
		for (int i = 0; i < 3; i++) begin
			m <= fasc_misc_type'(16'h0100 | (16'h0400 >> i));
			wt(10);
			chk(o.buzzer, 32'(i < 2));
		end
		rst();
		m <= fasc_misc_type'(16'h0800);
		wt(10);
		chk(o.self_test, 1'b0);
		m <= fasc_misc_type'(16'h5800);
		wt(10);
		chk(o.self_test, 1'b0);
		m <= fasc_misc_type'(16'h1800);
		wt(10);
		chk(o.self_test, 1'b1);
		m <= fasc_misc_type'(16'h2880);
		wt(10);
		pr();
		chk(o.self_test, 1'b0);
		m <= fasc_misc_type'(16'h2800);
		wt(10);
		chk(o.self_test, 1'b1);
		stop_test();
	end
endmodule : tb_fasc_top
`default_nettype wire
